// ---- jtag_prog_map.vh ----
// constants for the test-port programming chains
`ifndef JTAG_PROG_MAP_VH
`define JTAG_PROG_MAP_VH

// tap controller state codes
`define TAP_RESET      4'h0
`define TAP_IDLE       4'h1
`define TAP_SEL_DR     4'h2
`define TAP_CAP_DR     4'h3
`define TAP_SH_DR      4'h4
`define TAP_EX1_DR     4'h5
`define TAP_PA_DR      4'h6
`define TAP_EX2_DR     4'h7
`define TAP_UP_DR      4'h8
`define TAP_SEL_IR     4'h9
`define TAP_CAP_IR     4'ha
`define TAP_SH_IR      4'hb
`define TAP_EX1_IR     4'hc
`define TAP_PA_IR      4'hd
`define TAP_EX2_IR     4'he
`define TAP_UP_IR      4'hf

// instruction register
`define IR_WIDTH       4
`define IR_CAPTURE     4'h1
`define IR_RESET_VAL   4'hf
`define INS_ENABLE_KEY 4'h4
`define INS_COMMAND    4'h5
`define INS_PAGE_LOAD  4'h6
`define INS_PAGE_READ  4'h7
`define INS_RESET      4'hc

// data register widths
`define KEY_WIDTH      16
`define CMD_WIDTH      15
`define BYTE_WIDTH     8
`define BIT_CNT_WIDTH  3
`define PAGE_IDX_WIDTH 8
`define BIT_CNT_LAST   3'h7
`define KEY_VALUE      16'ha370
`define KEY_CLEAR      16'h0000
`define CMD_CLEAR      15'h0000
`define BYTE_CLEAR     8'h00

// command word fields and known words
`define CMD_PFX_HI     14
`define CMD_PFX_LO     8
`define PFX_ENTER      7'h23
`define CMD_CHIP_ERASE 15'h2380
`define CMD_ERASE_GO   15'h3180
`define CMD_ERASE_POLL 15'h3380
`define CMD_FLASH_WR   15'h2310
`define CMD_FLASH_RD   15'h2302
`define CMD_EE_WR      15'h2311
`define CMD_EE_RD      15'h2303
`define PFX_ADDR_HI    7'h07
`define PFX_ADDR_LO    7'h03
`define PFX_DATA_LO    7'h13
`define PFX_DATA_HI    7'h17
`define PFX_LATCH      7'h77
`define PFX_FL_PAGE_WR 7'h35
`define PFX_EE_PAGE_WR 7'h31

// reset time-out counter width
`define TMO_WIDTH      16
`define TMO_ZERO       16'h0000
`define TMO_ONE        16'h0001

`endif

// ---- tap_controller.v ----
// test access port state machine and instruction register
`timescale 1ns/100ps
`include "jtag_prog_map.vh"

module tap_controller (
  input  wire                  clock,
  input  wire                  sys_rst,
  input  wire                  tck_rise,
  input  wire                  tms,
  input  wire                  tdi,
  output reg  [3:0]            state,
  output reg  [`IR_WIDTH-1:0]  instr,
  output wire                  ir_lsb
);

  reg [3:0]            next_state;
  reg [`IR_WIDTH-1:0]  ir_shift;

  assign ir_lsb = ir_shift[0];

  // standard sixteen-state walk driven by tms
  always @* begin
    case (state)
      `TAP_RESET:  next_state = tms ? `TAP_RESET  : `TAP_IDLE;
      `TAP_IDLE:   next_state = tms ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_DR: next_state = tms ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR: next_state = tms ? `TAP_EX1_DR : `TAP_SH_DR;
      `TAP_SH_DR:  next_state = tms ? `TAP_EX1_DR : `TAP_SH_DR;
      `TAP_EX1_DR: next_state = tms ? `TAP_UP_DR  : `TAP_PA_DR;
      `TAP_PA_DR:  next_state = tms ? `TAP_EX2_DR : `TAP_PA_DR;
      `TAP_EX2_DR: next_state = tms ? `TAP_UP_DR  : `TAP_SH_DR;
      `TAP_UP_DR:  next_state = tms ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_IR: next_state = tms ? `TAP_RESET  : `TAP_CAP_IR;
      `TAP_CAP_IR: next_state = tms ? `TAP_EX1_IR : `TAP_SH_IR;
      `TAP_SH_IR:  next_state = tms ? `TAP_EX1_IR : `TAP_SH_IR;
      `TAP_EX1_IR: next_state = tms ? `TAP_UP_IR  : `TAP_PA_IR;
      `TAP_PA_IR:  next_state = tms ? `TAP_EX2_IR : `TAP_PA_IR;
      `TAP_EX2_IR: next_state = tms ? `TAP_UP_IR  : `TAP_SH_IR;
      `TAP_UP_IR:  next_state = tms ? `TAP_SEL_DR : `TAP_IDLE;
      default:     next_state = `TAP_RESET;
    endcase
  end

  // state and instruction advance only on a tck rising edge
  always @(posedge clock) begin
    if (sys_rst) begin
      state    <= `TAP_RESET;
      instr    <= `IR_RESET_VAL;
      ir_shift <= `IR_RESET_VAL;
    end else if (tck_rise) begin
      state <= next_state;
      case (state)
        `TAP_RESET: begin
          instr <= `IR_RESET_VAL;
        end
        `TAP_CAP_IR: begin
          ir_shift <= `IR_CAPTURE;
        end
        `TAP_SH_IR: begin
          ir_shift <= {tdi, ir_shift[`IR_WIDTH-1:1]}; // lsb first
        end
        `TAP_UP_IR: begin
          instr <= ir_shift;
        end
        default: begin
          instr <= instr;
        end
      endcase
    end
  end

endmodule

// ---- jtag_prog_chains.v ----
// test-port programming data registers for flash and eeprom
//
// Behaviour
// - command instruction puts a 15-bit command register between tdi and tdo
// - capture-dr loads the command register with the previous command result
// - shift-dr shifts command register each tck, result out, command in
// - update-dr presents the shifted command word to the memory controls
// - run-test/idle issues one internal strobe executing the applied command
// - page-load chain is 2048 bits on an 8-bit register, no update transfer
// - each completed page-load byte is written to the page buffer at once
// - page-read chain is 2056 bits on an 8-bit register, no capture transfer
// - page-read shift fetches bytes one by one onto tdo, tdi ignored
// - a one in the reset chain holds the part in reset
// - reset chain is unlatched; reset lasts a time-out after release
// - programming enabled only while the key equals 1010_0011_0111_0000
// - key register clears at power-on; programmer clears it when leaving
// - chip erase sequence of command words, completion polled by status bit
// - flash write: enter, address high and low, data low and high bytes
// - latch pulse into page buffer, page write pulse, then status poll
// - flash read: enter, address, then commands returning low and high byte
// - eeprom write: enter, address, one data byte, latch, page write, poll
// - eeprom read entered by its command then address high byte
// - every shift register moves least significant bit first
`timescale 1ns/100ps
`include "jtag_prog_map.vh"

module jtag_prog_chains #(
  parameter [`TMO_WIDTH-1:0] RESET_TIMEOUT_CYCLES = 16'h0040
) (
  input  wire                        clock,
  input  wire                        sys_rst,
  input  wire                        tck,
  input  wire                        tms,
  input  wire                        tdi,
  output reg                         tdo,
  output reg                         tdo_oe_n,
  output reg                         part_reset,
  output reg                         prog_enabled,
  output reg  [`CMD_WIDTH-1:0]       nvm_cmd,
  output reg                         nvm_cmd_strobe,
  output reg  [`BYTE_WIDTH-1:0]      nvm_mode,
  input  wire [`CMD_WIDTH-1:0]       nvm_result,
  output reg  [`BYTE_WIDTH-1:0]      page_wr_data,
  output reg  [`PAGE_IDX_WIDTH-1:0]  page_wr_addr,
  output reg                         page_wr_strobe,
  output reg  [`PAGE_IDX_WIDTH-1:0]  page_rd_addr,
  input  wire [`BYTE_WIDTH-1:0]      page_rd_data
);

  // pin synchronisers: first stage feeds only the second
  reg tck_m;
  reg tck_s;
  reg tck_d;
  reg tms_m;
  reg tms_s;
  reg tdi_m;
  reg tdi_s;

  wire tck_rise;
  wire tck_fall;

  // tap state and instruction
  wire [3:0]            state;
  wire [`IR_WIDTH-1:0]  instr;
  wire                  ir_lsb;

  // data registers
  reg                       reset_bit;
  reg                       bypass_bit;
  reg [`KEY_WIDTH-1:0]      key_shift;
  reg [`KEY_WIDTH-1:0]      key_reg;
  reg [`CMD_WIDTH-1:0]      cmd_shift;
  reg                       cmd_pending;
  reg [`BYTE_WIDTH-1:0]     load_shift;
  reg [`BIT_CNT_WIDTH-1:0]  load_cnt;
  reg [`BYTE_WIDTH-1:0]     read_shift;
  reg [`BIT_CNT_WIDTH-1:0]  read_cnt;
  reg [`TMO_WIDTH-1:0]      tmo_cnt;

  reg                       next_tdo;

  wire sel_reset;
  wire sel_key;
  wire sel_cmd;
  wire sel_load;
  wire sel_read;
  wire key_ok;
  wire [`BYTE_WIDTH-1:0] load_byte;

  // tck edges from the clock; held high in reset, so no false rise
  always @(posedge clock) begin
    if (sys_rst) begin
      tck_m <= 1'b1;
      tck_s <= 1'b1;
      tck_d <= 1'b1;
      tms_m <= 1'b1;
      tms_s <= 1'b1;
      tdi_m <= 1'b0;
      tdi_s <= 1'b0;
    end else begin
      tck_m <= tck;
      tck_s <= tck_m;
      tck_d <= tck_s;
      tms_m <= tms;
      tms_s <= tms_m;
      tdi_m <= tdi;
      tdi_s <= tdi_m;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  tap_controller u_tap (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .tck_rise (tck_rise),
    .tms      (tms_s),
    .tdi      (tdi_s),
    .state    (state),
    .instr    (instr),
    .ir_lsb   (ir_lsb)
  );

  // instruction decode selects the data register
  assign sel_reset = (instr == `INS_RESET);
  assign sel_key   = (instr == `INS_ENABLE_KEY);
  assign sel_cmd   = (instr == `INS_COMMAND);
  assign sel_load  = (instr == `INS_PAGE_LOAD);
  assign sel_read  = (instr == `INS_PAGE_READ);
  assign key_ok    = (key_reg == `KEY_VALUE);
  assign load_byte = {tdi_s, load_shift[`BYTE_WIDTH-1:1]};

  // reset chain: one bit, its output not latched behind update-dr
  always @(posedge clock) begin
    if (sys_rst) begin
      reset_bit <= 1'b0;
    end else if (tck_rise && sel_reset && state == `TAP_SH_DR) begin
      reset_bit <= tdi_s;
    end
  end

  // part reset follows the chain, then holds for the time-out
  always @(posedge clock) begin
    if (sys_rst) begin
      tmo_cnt    <= `TMO_ZERO;
      part_reset <= 1'b0;
    end else begin
      if (reset_bit) begin
        tmo_cnt <= RESET_TIMEOUT_CYCLES;
      end else if (tmo_cnt != `TMO_ZERO) begin
        tmo_cnt <= tmo_cnt - `TMO_ONE;
      end
      part_reset <= reset_bit | (tmo_cnt != `TMO_ZERO);
    end
  end

  // bypass bit for every instruction without its own register
  always @(posedge clock) begin
    if (sys_rst) begin
      bypass_bit <= 1'b0;
    end else if (tck_rise) begin
      if (state == `TAP_CAP_DR) begin
        bypass_bit <= 1'b0;
      end else if (state == `TAP_SH_DR) begin
        bypass_bit <= tdi_s;
      end
    end
  end

  // enable key: shifted in, compared once update-dr takes it
  always @(posedge clock) begin
    if (sys_rst) begin
      key_shift    <= `KEY_CLEAR;
      key_reg      <= `KEY_CLEAR;
      prog_enabled <= 1'b0;
    end else begin
      if (tck_rise && sel_key && state == `TAP_SH_DR) begin
        key_shift <= {tdi_s, key_shift[`KEY_WIDTH-1:1]};
      end
      if (tck_rise && sel_key && state == `TAP_UP_DR) begin
        key_reg <= key_shift;
      end
      prog_enabled <= key_ok;
    end
  end

  // command register: capture result, shift, apply, execute once
  always @(posedge clock) begin
    if (sys_rst) begin
      cmd_shift      <= `CMD_CLEAR;
      nvm_cmd        <= `CMD_CLEAR;
      nvm_mode       <= `BYTE_CLEAR;
      cmd_pending    <= 1'b0;
      nvm_cmd_strobe <= 1'b0;
    end else begin
      nvm_cmd_strobe <= 1'b0;
      if (tck_rise && sel_cmd) begin
        case (state)
          `TAP_CAP_DR: begin
            cmd_shift <= nvm_result;
          end
          `TAP_SH_DR: begin
            cmd_shift <= {tdi_s, cmd_shift[`CMD_WIDTH-1:1]};
          end
          `TAP_UP_DR: begin
            // without the key the word never reaches the memory
            if (key_ok) begin
              nvm_cmd     <= cmd_shift;
              cmd_pending <= 1'b1;
              if (cmd_shift[`CMD_PFX_HI:`CMD_PFX_LO] == `PFX_ENTER) begin
                // mode byte kept across sequences
                nvm_mode <= cmd_shift[`BYTE_WIDTH-1:0];
              end
            end
          end
          `TAP_IDLE: begin
            // one strobe per applied word, however long idle lasts
            if (cmd_pending && key_ok) begin
              nvm_cmd_strobe <= 1'b1;
              cmd_pending    <= 1'b0;
            end
          end
          default: begin
            cmd_pending <= cmd_pending;
          end
        endcase
      end
      if (!key_ok) begin
        cmd_pending <= 1'b0;
      end
    end
  end

  // page load: each eighth shifted bit completes a byte for the buffer
  always @(posedge clock) begin
    if (sys_rst) begin
      load_shift     <= `BYTE_CLEAR;
      load_cnt       <= {`BIT_CNT_WIDTH{1'b0}};
      page_wr_data   <= `BYTE_CLEAR;
      page_wr_addr   <= {`PAGE_IDX_WIDTH{1'b0}};
      page_wr_strobe <= 1'b0;
    end else begin
      page_wr_strobe <= 1'b0;
      if (tck_rise && sel_load && state == `TAP_CAP_DR) begin
        load_cnt     <= {`BIT_CNT_WIDTH{1'b0}};
        page_wr_addr <= {`PAGE_IDX_WIDTH{1'b0}};
      end else if (tck_rise && sel_load && state == `TAP_SH_DR) begin
        load_shift <= load_byte;
        load_cnt   <= load_cnt + 3'h1;
        if (load_cnt == `BIT_CNT_LAST && key_ok) begin
          page_wr_data   <= load_byte;
          page_wr_strobe <= 1'b1;
        end
      end
      // address steps after the strobe so the byte lands at its index
      if (page_wr_strobe) begin
        page_wr_addr <= page_wr_addr + 8'h01;
      end
    end
  end

  // page read: first byte out is stale, then the page byte by byte
  always @(posedge clock) begin
    if (sys_rst) begin
      read_shift   <= `BYTE_CLEAR;
      read_cnt     <= {`BIT_CNT_WIDTH{1'b0}};
      page_rd_addr <= {`PAGE_IDX_WIDTH{1'b0}};
    end else if (tck_rise && sel_read) begin
      if (state == `TAP_CAP_DR) begin
        // counters restart; the shift register keeps its content
        read_cnt     <= {`BIT_CNT_WIDTH{1'b0}};
        page_rd_addr <= {`PAGE_IDX_WIDTH{1'b0}};
      end else if (state == `TAP_SH_DR) begin
        read_cnt <= read_cnt + 3'h1;
        if (read_cnt == `BIT_CNT_LAST) begin
          read_shift   <= key_ok ? page_rd_data : `BYTE_CLEAR;
          page_rd_addr <= page_rd_addr + 8'h01;
        end else begin
          read_shift <= {1'b0, read_shift[`BYTE_WIDTH-1:1]};
        end
      end
    end
  end

  // tdo source for the selected register
  always @* begin
    if (state == `TAP_SH_IR) begin
      next_tdo = ir_lsb;
    end else if (sel_reset) begin
      next_tdo = reset_bit;
    end else if (sel_key) begin
      next_tdo = key_shift[0];
    end else if (sel_cmd) begin
      next_tdo = cmd_shift[0];
    end else if (sel_load) begin
      next_tdo = load_shift[0];
    end else if (sel_read) begin
      next_tdo = read_shift[0];
    end else begin
      next_tdo = bypass_bit;
    end
  end

  // tdo changes on the falling tck edge, driven only while shifting
  always @(posedge clock) begin
    if (sys_rst) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo      <= next_tdo;
      tdo_oe_n <= ~(state == `TAP_SH_DR || state == `TAP_SH_IR);
    end
  end

endmodule

// ---- jtag_prog_chains_checker.sv ----
// assertions on the programming chain ports
`timescale 1ns/100ps
`include "jtag_prog_map.vh"
module jtag_prog_chains_checker #(
  parameter [15:0] RESET_TIMEOUT_CYCLES = 16'h0040
) (
  input wire        clock,
  input wire        sys_rst,
  input wire        tck,
  input wire        tdo,
  input wire        part_reset,
  input wire        prog_enabled,
  input wire [14:0] nvm_cmd,
  input wire        nvm_cmd_strobe,
  input wire [7:0]  nvm_mode,
  input wire [7:0]  page_wr_addr,
  input wire        page_wr_strobe
);
  reg [15:0] hi_run;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // cycles part_reset has stood high, saturating
  always @(posedge clock) begin
    if (sys_rst || !part_reset) hi_run <= 16'h0000;
    else if (hi_run != 16'hffff) hi_run <= hi_run + 16'h0001;
  end
  property p_strobe_pulse; nvm_cmd_strobe |=> !nvm_cmd_strobe; endproperty
  property p_strobe_key; nvm_cmd_strobe |-> prog_enabled; endproperty
  property p_pw_key; page_wr_strobe |-> prog_enabled; endproperty
  // next strobe is ten clocks away at least, so two cycles is safe
  property p_pw_addr;
    page_wr_strobe |-> ##2 page_wr_addr == $past(page_wr_addr, 2) + 8'h01;
  endproperty
  property p_rst_clear;
    disable iff (1'b0)
    $fell(sys_rst) |-> !prog_enabled && nvm_cmd == 15'h0000 && !part_reset;
  endproperty
  // tdo may move only while the tck pin is low
  property p_tdo_fall; $changed(tdo) |-> !tck; endproperty
  property p_reset_hold;
    $fell(part_reset) |-> hi_run >= RESET_TIMEOUT_CYCLES;
  endproperty
  property p_mode;
    $changed(nvm_mode) |-> nvm_cmd[14:8] == `PFX_ENTER
      && nvm_mode == nvm_cmd[7:0];
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("strobe longer than one clock");
  a_strobe_key: assert property (p_strobe_key)
    else $error("strobe without key");
  a_pw_key: assert property (p_pw_key)
    else $error("page write without key");
  a_pw_addr: assert property (p_pw_addr)
    else $error("page index did not step by one");
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not cleared by reset");
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo moved while tck high");
  a_reset_hold: assert property (p_reset_hold)
    else $error("part reset released early");
  a_mode: assert property (p_mode)
    else $error("mode byte not from an enter command");
  c_strobe: cover property (nvm_cmd_strobe);
  c_page_end: cover property (page_wr_strobe && page_wr_addr == 8'hff);
  c_reset_end: cover property ($fell(part_reset));
endmodule
bind jtag_prog_chains jtag_prog_chains_checker #(
  .RESET_TIMEOUT_CYCLES(RESET_TIMEOUT_CYCLES)
) u_chk (
  .clock, .sys_rst, .tck, .tdo, .part_reset, .prog_enabled, .nvm_cmd,
  .nvm_cmd_strobe, .nvm_mode, .page_wr_addr, .page_wr_strobe
);

// ---- jtag_programmer.sv ----
// programmer model driving the test access port pins
`timescale 1ns/100ps
module jtag_programmer (
  input  wire clock,
  input  wire tdo,
  output reg  tck,
  output reg  tms,
  output reg  tdi
);
  integer j;
  integer k;
  reg     o;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period of 10 clocks; tdo taken just before the rise
  task tick(input m, input d, output q);
    begin
      tms <= m;
      tdi <= d;
      tck <= 1'b0;
      repeat (5) @(posedge clock);
      q = tdo;
      tck <= 1'b1;
      repeat (5) @(posedge clock);
    end
  endtask
  // walk the tap by a tms pattern; tdi shows junk outside shifts
  task nav(input [3:0] p, input integer n);
    for (j = 0; j < n; j = j + 1)
      tick(p[j], ~tdi, o);
  endtask
  // scan n bits through the ir or a data register, then back to idle
  task scan(input sel_ir, input integer n, input [2055:0] din,
            output [2055:0] dout);
    begin
      dout = {2056{1'b0}};
      nav(sel_ir ? 4'b0011 : 4'b0001, sel_ir ? 4 : 3);
      for (k = 0; k < n; k = k + 1)
        tick(k == n - 1, din[k], dout[k]);
      nav(4'b0001, 2);
    end
  endtask
  task idle(input integer n);
    nav(4'b0000, n);
  endtask
endmodule

// ---- jtag_memory_programming_chains_tb.sv ----
// bench for the test-port programming chains
`timescale 1ns/100ps
`include "jtag_prog_map.vh"
`define CHK(nm, e, g) begin num_checks = num_checks + 1; \
  if ((g) !== (e)) begin fail_count = fail_count + 1; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module jtag_memory_programming_chains_tb;
  localparam [15:0] TMO = 16'h0028;
  reg           clock = 1'b0;
  reg           sys_rst = 1'b1;
  reg  [14:0]   nvm_result = 15'h0000;
  reg  [7:0]    page_rd_data = 8'h00;
  wire          tck, tms, tdi, tdo, tdo_oe_n, part_reset, prog_enabled;
  wire          nvm_cmd_strobe, page_wr_strobe;
  wire [14:0]   nvm_cmd;
  wire [7:0]    nvm_mode, page_wr_data, page_wr_addr, page_rd_addr;
  wire          tdo_line;
  integer       fail_count = 0, num_checks = 0, seed = 47259, k;
  reg  [2055:0] din, dout;
  reg  [14:0]   cq[$];
  reg  [15:0]   pq[$];
  reg  [14:0]   e15, c;
  reg  [15:0]   e16;
  reg  [31:0]   rnd;
  // prefix-only steps are left out where the last word set them
  reg  [14:0]   seqs[0:29] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380,
    15'h2310, 15'h0700, 15'h0300, 15'h1300, 15'h1700, 15'h3700, 15'h7700,
    15'h3700, 15'h3500, 15'h3700, 15'h2302, 15'h0700, 15'h0300, 15'h3200,
    15'h3600, 15'h3700, 15'h2311, 15'h0700, 15'h0300, 15'h1300, 15'h7700,
    15'h3300, 15'h3100, 15'h3300, 15'h2303, 15'h0700};
  jtag_prog_chains #(.RESET_TIMEOUT_CYCLES(TMO)) u_dut (
    .clock, .sys_rst, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .part_reset,
    .prog_enabled, .nvm_cmd, .nvm_cmd_strobe, .nvm_mode, .nvm_result,
    .page_wr_data, .page_wr_addr, .page_wr_strobe, .page_rd_addr,
    .page_rd_data);
  // a released tdo shows the inverse, so a bit read while undriven is wrong
  assign tdo_line = tdo_oe_n ? ~tdo : tdo;
  jtag_programmer u_prog (.clock, .tdo(tdo_line), .tck, .tms, .tdi);
  always #4 clock = ~clock;
  // page memory answers one clock after the index
  always @(posedge clock) page_rd_data <= page_rd_addr ^ 8'h5a;
  // oldest note against each result; an unexpected strobe meets x
  always @(posedge clock) begin
    if (nvm_cmd_strobe) begin
      e15 = cq.size() ? cq.pop_front() : 15'hxxxx;
      `CHK("nvm_cmd", e15, nvm_cmd)
    end
    if (page_wr_strobe) begin
      e16 = pq.size() ? pq.pop_front() : 16'hxxxx;
      `CHK("page_wr", e16, {page_wr_addr, page_wr_data})
    end
  end
  task sel(input [3:0] code);
    begin
      u_prog.scan(1, 4, {2052'h0, code}, dout);
      `CHK("ir capture", 4'h1, dout[3:0])
    end
  endtask
  // one command word; en says the key is loaded
  task cmd(input [14:0] w, input [14:0] res, input en);
    begin
      nvm_result <= res;
      u_prog.scan(0, 15, {2041'h0, w}, dout);
      if (en) cq.push_back(w);
      u_prog.idle(2);
      if (en) `CHK("result", res, dout[14:0])
      if (en && w[14:8] == `PFX_ENTER)
        `CHK("mode", w[7:0], nvm_mode)
    end
  endtask
  task key(input [15:0] v, input exp);
    begin
      sel(4'h4);
      u_prog.scan(0, 16, {2040'h0, v}, dout);
      `CHK("prog_enabled", exp, prog_enabled)
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    `CHK("key at reset", 1'b0, prog_enabled)
    u_prog.idle(1);
    `CHK("oe idle", 1'b1, tdo_oe_n)
    // without the key nothing reaches the memory side
    sel(4'h5);
    cmd(`CMD_CHIP_ERASE, 15'h0000, 1'b0);
    sel(4'h6);
    u_prog.scan(0, 16, {2056{1'b1}}, dout);
    // hold the part in reset before programming
    sel(4'hc);
    u_prog.scan(0, 1, {2056{1'b1}}, dout);
    `CHK("reset on", 1'b1, part_reset)
    u_prog.scan(0, 1, {2056{1'b0}}, dout);
    `CHK("reset hold", 1'b1, part_reset)
    k = 0;
    while (part_reset && k < 200) begin
      @(posedge clock);
      k = k + 1;
    end
    `CHK("reset release", 1'b0, part_reset)
    key(16'ha371, 1'b0);
    key(16'ha370, 1'b1);
    // every sequence of the table, address and data bytes random
    sel(4'h5);
    for (k = 0; k < 30; k = k + 1) begin
      c = seqs[k];
      rnd = $random(seed);
      if (c[14:11] <= 4'h2) c[7:0] = rnd[22:15];
      cmd(c, rnd[14:0], 1'b1);
    end
    // poll until the status bit answers one
    k = 0;
    dout = {2056{1'b0}};
    while (!dout[9] && k < 8) begin
      rnd = $random(seed);
      rnd[9] = (k >= 2);
      cmd(`CMD_ERASE_POLL, rnd[14:0], 1'b1);
      k = k + 1;
    end
    `CHK("poll", 1'b1, dout[9])
    // one full page in, each byte noted with its index
    sel(4'h6);
    for (k = 0; k < 64; k = k + 1) din[32*k +: 32] = $random(seed);
    for (k = 0; k < 256; k = k + 1) pq.push_back({k[7:0], din[8*k +: 8]});
    u_prog.scan(0, 2048, din, dout);
    sel(4'h7);
    u_prog.scan(0, 2056, ~din, dout);
    for (k = 0; k < 256; k = k + 1)
      `CHK("page_rd", k[7:0] ^ 8'h5a, dout[8*k+8 +: 8])
    // a reset in mid run drops the key
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    `CHK("key after reset", 1'b0, prog_enabled)
    u_prog.idle(1);
    // instruction left by reset selects the one-bit bypass
    u_prog.scan(0, 2, {2054'h0, 2'b01}, dout);
    `CHK("bypass", 2'b10, dout[1:0])
    key(16'ha370, 1'b1);
    key(16'h0000, 1'b0);
    sel(4'h5);
    cmd(15'h3700, 15'h0000, 1'b0);
    `CHK("notes left", 0, cq.size() + pq.size())
    print_verdict;
  end
endmodule
